// file: inc/flash_cfg_pkg.sv
// constants for the configuration and status register block of a serial flash
// assumes the serial command framing: 8-bit opcode, 16-bit fields, msb first
package flash_cfg_pkg;

  // opcodes handled here
  localparam logic [7:0] CMD_READ_CFG   = 8'h8b;
  localparam logic [7:0] CMD_WRITE_CFG  = 8'h8a;
  localparam logic [7:0] CMD_READ_STAT  = 8'h83;
  localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_CLR_CMP    = 8'h89;

  // configuration word
  localparam logic [15:0] CFG_RESET      = 16'h0009;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h01ff;
  localparam int          CFG_PUMP_BIT   = 8;
  localparam int          CFG_RANGE_MSB  = 7;
  localparam int          CFG_RANGE_LSB  = 4;
  localparam int          CFG_DIR_BIT    = 3;
  localparam int          CFG_EDGE_BIT   = 2;
  localparam int          CFG_PIN_MSB    = 1;
  localparam int          CFG_PIN_LSB    = 0;

  // protection range
  localparam logic [3:0] RANGE_NONE  = 4'h0;
  localparam logic [3:0] RANGE_ALL   = 4'hf;
  localparam int         BLOCK_SHIFT = 5;

  // dual-purpose pin functions
  localparam logic [1:0] PIN_SUSPEND = 2'h0;
  localparam logic [1:0] PIN_NC      = 2'h1;
  localparam logic [1:0] PIN_RB_OD   = 2'h2;
  localparam logic [1:0] PIN_RB_PP   = 2'h3;

  // status word bit positions
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_XFER_BIT = 6;
  localparam int ST_WE_BIT   = 4;
  localparam int ST_CMP_BIT  = 3;

  // frame bit counts, in sck rising edges
  localparam logic [6:0] CNT_OPCODE   = 7'h08;
  localparam logic [6:0] CNT_CFG_DATA = 7'h18;
  localparam logic [6:0] CNT_CTRL_END = 7'h38;
  localparam logic [6:0] CNT_DATA_LO  = 7'h48;
  localparam logic [6:0] CNT_WRAP     = 7'h57;

  // ready/busy word sent before read data
  localparam logic [15:0] RB_READY = 16'h9999;
  localparam logic [15:0] RB_BUSY  = 16'h6666;

endpackage : flash_cfg_pkg

// file: verilog/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes every bit is an independent level; no bus coherence implied
`timescale 1ns/100ps
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // reset level per pin must match the edge detectors behind it, else a false edge follows reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : pin_sync

// file: verilog/flash_cfg_regs.sv
// configuration and status register logic of a serial flash, seen from the serial pins
// assumes sck, cs_n, si, wp_n and the dual pin are asynchronous; the array core is on clk_i
`timescale 1ns/100ps
module flash_cfg_regs #(
  parameter int SECTOR_W = 9
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                sck_i,
  input  wire logic                cs_n_i,
  input  wire logic                si_i,
  input  wire logic                wp_n_i,
  output logic                     so_o,
  output logic                     so_oe_o,
  input  wire logic                dual_pin_i,
  output logic                     dual_pin_o,
  output logic                     dual_pin_oe_o,
  input  wire logic                array_busy_i,
  input  wire logic                xfer_busy_i,
  input  wire logic                cmp_valid_i,
  input  wire logic                cmp_mismatch_i,
  input  wire logic [SECTOR_W-1:0] wr_sector_i,
  output logic                     wr_allowed_o,
  output logic                     alt_pump_freq_o,
  input  wire logic [15:0]         nv_cfg_i,
  output logic [15:0]              nv_wdata_o,
  output logic                     nv_write_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [4:0] pins_s;
  logic       sck_s;
  logic       cs_n_s;
  logic       si_s;
  logic       wp_n_s;
  logic       dual_s;

  pin_sync #(.W(5), .RST_VAL(5'h1f)) u_pin_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({sck_i, cs_n_i, si_i, wp_n_i, dual_pin_i}),
    .q_o       (pins_s)
  );

  assign {sck_s, cs_n_s, si_s, wp_n_s, dual_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields and derived state

  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [3:0]  range_code;
  logic        protect_from_top;
  logic        out_edge_select;
  logic [1:0]  dual_pin_function;
  logic        busy;
  logic        hold_active;
  logic [7:0]  status_bits;
  logic        we_q;
  logic        we_d;
  logic        mismatch_q;
  logic        mismatch_d;

  assign range_code        = cfg_q[flash_cfg_pkg::CFG_RANGE_MSB:flash_cfg_pkg::CFG_RANGE_LSB];
  assign protect_from_top  = cfg_q[flash_cfg_pkg::CFG_DIR_BIT];
  assign out_edge_select   = cfg_q[flash_cfg_pkg::CFG_EDGE_BIT];
  assign dual_pin_function = cfg_q[flash_cfg_pkg::CFG_PIN_MSB:flash_cfg_pkg::CFG_PIN_LSB];
  assign alt_pump_freq_o   = cfg_q[flash_cfg_pkg::CFG_PUMP_BIT];
  assign busy              = array_busy_i | xfer_busy_i;

  // suspend only counts when the pin is configured as an input
  assign hold_active = (dual_pin_function == flash_cfg_pkg::PIN_SUSPEND) & ~dual_s;

  always_comb
  begin
    status_bits                             = 8'h00;
    status_bits[flash_cfg_pkg::ST_BUSY_BIT] = busy;
    status_bits[flash_cfg_pkg::ST_XFER_BIT] = xfer_busy_i;
    status_bits[flash_cfg_pkg::ST_WE_BIT]   = we_q;
    status_bits[flash_cfg_pkg::ST_CMP_BIT]  = mismatch_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial frame: edge detect, bit count, opcode and data capture

  logic       sck_prev_q;
  logic       cs_prev_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic [7:0]  opcode_q;
  logic [7:0]  opcode_d;
  logic [15:0] cfg_in_q;
  logic [15:0] cfg_in_d;
  logic        wp_seen_q;
  logic        wp_seen_d;

  // frozen edges while suspended keep the partial command intact
  assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s & ~hold_active;
  assign sck_fall = ~sck_s & sck_prev_q & ~cs_n_s & ~hold_active;
  assign cs_rise  = cs_n_s & ~cs_prev_q;

  always_comb
  begin
    cnt_d     = cnt_q;
    sr_d      = sr_q;
    opcode_d  = opcode_q;
    cfg_in_d  = cfg_in_q;
    wp_seen_d = wp_seen_q | (~cs_n_s & ~wp_n_s);
    if (cs_n_s)
    begin
      cnt_d     = 7'h00;
      wp_seen_d = 1'b0;
    end
    else if (sck_rise)
    begin
      sr_d  = {sr_q[14:0], si_s};
      // read streams repeat their data field past the wrap point
      cnt_d = (cnt_q == flash_cfg_pkg::CNT_WRAP) ? flash_cfg_pkg::CNT_DATA_LO : cnt_q + 7'h01;
      if (cnt_d == flash_cfg_pkg::CNT_OPCODE)
        opcode_d = sr_d[7:0];
      if (cnt_d == flash_cfg_pkg::CNT_CFG_DATA)
        cfg_in_d = sr_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_prev_q <= 1'b1;
      cs_prev_q  <= 1'b1;
      cnt_q      <= 7'h00;
      sr_q       <= 16'h0000;
      opcode_q   <= 8'h00;
      cfg_in_q   <= 16'h0000;
      wp_seen_q  <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
      cnt_q      <= cnt_d;
      sr_q       <= sr_d;
      opcode_q   <= opcode_d;
      cfg_in_q   <= cfg_in_d;
      wp_seen_q  <= wp_seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register updates at the end of a frame, after reset and on a compare mismatch

  logic load_pend_q;
  logic load_pend_d;
  logic nv_write_d;
  logic [15:0] nv_wdata_d;
  logic cfg_cmd_ok;

  // a configuration write landing mid-program is dropped, not queued
  assign cfg_cmd_ok = cs_rise & (opcode_q == flash_cfg_pkg::CMD_WRITE_CFG)
                      & (cnt_q >= flash_cfg_pkg::CNT_CFG_DATA) & ~busy;

  always_comb
  begin
    cfg_d       = cfg_q;
    load_pend_d = 1'b0;
    nv_write_d  = 1'b0;
    nv_wdata_d  = nv_wdata_o;
    we_d        = we_q;
    mismatch_d  = mismatch_q;
    if (load_pend_q)
      cfg_d = nv_cfg_i & flash_cfg_pkg::CFG_WRITE_MASK;
    else if (cfg_cmd_ok)
    begin
      // reserved bits never reach a function
      cfg_d      = cfg_in_q & flash_cfg_pkg::CFG_WRITE_MASK;
      nv_write_d = 1'b1;
      nv_wdata_d = cfg_d;
    end
    if (cs_rise && cnt_q >= flash_cfg_pkg::CNT_OPCODE)
    begin
      if (opcode_q == flash_cfg_pkg::CMD_WR_ENABLE)
        we_d = ~wp_seen_q;
      if (opcode_q == flash_cfg_pkg::CMD_WR_DISABLE)
        we_d = 1'b0;
      if (opcode_q == flash_cfg_pkg::CMD_CLR_CMP)
        mismatch_d = 1'b0;
    end
    if (cmp_valid_i && cmp_mismatch_i)
      mismatch_d = 1'b1;  // set beats clear
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q       <= flash_cfg_pkg::CFG_RESET;
      load_pend_q <= 1'b1;
      nv_write_o  <= 1'b0;
      nv_wdata_o  <= flash_cfg_pkg::CFG_RESET;
      we_q        <= 1'b0;
      mismatch_q  <= 1'b0;
    end
    else
    begin
      cfg_q       <= cfg_d;
      load_pend_q <= load_pend_d;
      nv_write_o  <= nv_write_d;
      nv_wdata_o  <= nv_wdata_d;
      we_q        <= we_d;
      mismatch_q  <= mismatch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output of ready/busy word then configuration or status

  logic       so_q;
  logic       so_d;
  logic       so_en_q;
  logic       so_en_d;
  logic [6:0] idx;
  logic       is_read;
  logic       drive_edge;
  logic       stream_bit;
  logic [15:0] rb_word;

  assign is_read    = (opcode_q == flash_cfg_pkg::CMD_READ_CFG) | (opcode_q == flash_cfg_pkg::CMD_READ_STAT);
  assign idx        = cnt_d - flash_cfg_pkg::CNT_CTRL_END;
  assign rb_word    = busy ? flash_cfg_pkg::RB_BUSY : flash_cfg_pkg::RB_READY;
  assign drive_edge = out_edge_select ? sck_rise : sck_fall;

  always_comb
  begin
    if (idx < 7'h10)
      stream_bit = rb_word[4'hf - idx[3:0]];
    else if (opcode_q == flash_cfg_pkg::CMD_READ_CFG)
      stream_bit = cfg_q[4'hf - idx[3:0]];
    else
      stream_bit = status_bits[3'h7 - idx[2:0]];
  end

  always_comb
  begin
    so_d    = so_q;
    so_en_d = so_en_q;
    if (cs_n_s)
      so_en_d = 1'b0;
    else if (drive_edge && is_read && cnt_d >= flash_cfg_pkg::CNT_CTRL_END)
    begin
      so_d    = stream_bit;
      so_en_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      so_q    <= 1'b0;
      so_en_q <= 1'b0;
    end
    else
    begin
      so_q    <= so_d;
      so_en_q <= so_en_d;
    end
  end

  assign so_o    = so_q;
  assign so_oe_o = so_en_q & ~cs_n_s & ~hold_active;

  ////////////////////////////////////////////////////////////////////////////
  // dual-purpose pin and write protection

  always_comb
  begin
    dual_pin_o    = ~busy;
    dual_pin_oe_o = 1'b0;
    if (dual_pin_function == flash_cfg_pkg::PIN_RB_OD)
      dual_pin_oe_o = busy;
    else if (dual_pin_function == flash_cfg_pkg::PIN_RB_PP)
      dual_pin_oe_o = 1'b1;
  end

  logic [SECTOR_W:0] span;
  logic [SECTOR_W:0] sector_ext;
  logic              in_range;

  assign span       = (SECTOR_W+1)'(range_code) << flash_cfg_pkg::BLOCK_SHIFT;
  assign sector_ext = {1'b0, wr_sector_i};

  always_comb
  begin
    if (range_code == flash_cfg_pkg::RANGE_NONE)
      in_range = 1'b0;
    else if (range_code == flash_cfg_pkg::RANGE_ALL)
      in_range = 1'b1;
    else if (protect_from_top)
      in_range = (sector_ext + span) >= (SECTOR_W+1)'(1 << SECTOR_W);
    else
      in_range = sector_ext < span;
  end

  // a low write-protect pin blocks everything, so the range only matters when high
  assign wr_allowed_o = we_q & wp_n_s & ~in_range;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_status_unused_zero: assert property (status_bits[5] == 1'b0 && status_bits[2:0] == 3'h0)
    else $error("unassigned status bits not zero");
  a_cfg_reserved_zero: assert property (cfg_q[15:9] == 7'h00)
    else $error("reserved configuration bits set");
  a_we_wp_refused: assert property (cs_rise && opcode_q == flash_cfg_pkg::CMD_WR_ENABLE && wp_seen_q
                                    && cnt_q >= flash_cfg_pkg::CNT_OPCODE |=> !we_q)
    else $error("write enable accepted with write-protect low");
  a_mismatch_sets: assert property (cmp_valid_i && cmp_mismatch_i |=> status_bits[flash_cfg_pkg::ST_CMP_BIT])
    else $error("mismatch not latched");
  a_mismatch_sticky: assert property (mismatch_q && !(cs_rise && opcode_q == flash_cfg_pkg::CMD_CLR_CMP)
                                      |=> mismatch_q)
    else $error("mismatch cleared without command");
  a_hold_floats_so: assert property (hold_active |-> !so_oe_o)
    else $error("so driven during suspend");
  a_hold_keeps_cmd: assert property (hold_active && !cs_n_s ##1 hold_active && !cs_n_s
                                     |-> $stable(cnt_q) && $stable(opcode_q))
    else $error("command state changed during suspend");
  a_rb_pin_busy: assert property (busy && dual_pin_function[1] |-> dual_pin_oe_o && !dual_pin_o)
    else $error("ready/busy pin not low while busy");
  a_xfer_shows_busy: assert property (xfer_busy_i |-> status_bits[7:6] == 2'h3)
    else $error("transfer without busy");
  a_protect_all: assert property (range_code == flash_cfg_pkg::RANGE_ALL |-> !wr_allowed_o)
    else $error("write allowed with full protection");
  a_rise_edge_start: assert property (out_edge_select && sck_rise && is_read
                                      && cnt_d == flash_cfg_pkg::CNT_CTRL_END |=> so_oe_o || cs_n_s || hold_active)
    else $error("so not driven after last control clock");
  a_pump_follows: assert property (!load_pend_q && !cfg_cmd_ok |=> $stable(alt_pump_freq_o))
    else $error("pump select changed without configuration write");

endmodule : flash_cfg_regs

// file: verif/spi_host_model.sv
// behavioural serial host driving the pins of the configuration/status block
// assumes clk_i is the block clock; sck is built 4 clk high, 4 clk low, idle low
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o
);
  initial
  begin
    sck_o    = 1'b0;
    cs_n_o   = 1'b1;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shifts nw bits of {op, fld} then zeros, samples nrd bits, pauses before bit susp
  task automatic frame(input logic [7:0] op, input logic [15:0] fld, input int nw, input int nrd,
                       input int susp, output logic [31:0] rd, output logic oe_e, output logic oe_s);
    logic [23:0] sh;
    sh = {op, fld};
    rd = '0;
    oe_e = 1'b0;
    oe_s = 1'b0;
    @(posedge clk_i) cs_n_o <= 1'b0;
    si_o <= sh[23];
    for (int i = 0; i < nw + nrd; i++)
    begin
      if (i == susp)
      begin
        @(posedge clk_i) hold_n_o <= 1'b0;
        si_o <= ~si_o;
        // sck keeps running while held; data on si must be dropped
        repeat (4)
        begin
          repeat (4) @(posedge clk_i);
          sck_o <= ~sck_o;
        end
        @(negedge clk_i) oe_s = so_oe_i;
        @(posedge clk_i) hold_n_o <= 1'b1;
        si_o <= sh[23];
      end
      repeat (3) @(posedge clk_i);
      @(posedge clk_i) sck_o <= 1'b1;
      // sampled early in the high phase, safe for either output edge
      // an undriven so reads back inverted, so a missing enable cannot pass
      @(negedge clk_i) if (i >= nw) rd = {rd[30:0], so_oe_i ? so_i : ~so_i};
      repeat (3) @(posedge clk_i);
      @(posedge clk_i) sck_o <= 1'b0;
      sh = sh << 1;
      si_o <= sh[23];
      @(negedge clk_i) if (i == nw - 1) oe_e = so_oe_i;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (8) @(posedge clk_i);
  endtask : frame
endmodule : spi_host_model

// file: verif/testbench.sv
// self-checking bench for the configuration/status register block
// assumes the serial host model drives sck at 320 ns; clk 40 ns
`timescale 1ns/100ps
module testbench;
  logic        clk_i, rst_n_i, sck, cs_n, si, wp_n, so, so_oe, hold_n, dual_o, dual_oe, dual_pin;
  logic        array_busy, xfer_busy, cmp_valid, cmp_mis, wr_allowed, alt_pump, nv_write;
  logic [8:0]  wr_sector;
  logic [15:0] nv_cfg, nv_wdata, nv_last;
  int          miscompares, compares, lim, s;

  // released open-drain pin is pulled up; host holds it high when idle
  assign dual_pin = dual_oe ? dual_o : hold_n;

  flash_cfg_regs #(.SECTOR_W(9)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n),
    .so_o(so), .so_oe_o(so_oe), .dual_pin_i(dual_pin), .dual_pin_o(dual_o), .dual_pin_oe_o(dual_oe),
    .array_busy_i(array_busy), .xfer_busy_i(xfer_busy), .cmp_valid_i(cmp_valid),
    .cmp_mismatch_i(cmp_mis), .wr_sector_i(wr_sector), .wr_allowed_o(wr_allowed),
    .alt_pump_freq_o(alt_pump), .nv_cfg_i(nv_cfg), .nv_wdata_o(nv_wdata), .nv_write_o(nv_write));

  spi_host_model host (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n),
                       .si_o(si), .hold_n_o(hold_n));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (nv_write) nv_last <= nv_wdata;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset(input logic [15:0] cells);
    @(posedge clk_i) rst_n_i <= 1'b0;
    nv_cfg <= cells;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : do_reset

  task automatic rd(input logic [7:0] op, input logic [31:0] exp, input logic eb, input int susp);
    logic [31:0] v;
    logic        oe_e;
    logic        oe_s;
    host.frame(op, 16'h0000, 56, 32, susp, v, oe_e, oe_s);
    check("read word", v, exp);
    check("so start", oe_e, eb);
    if (susp < 99) check("so while held", oe_s, 1'b0);
  endtask : rd

  task automatic rd_cfg(input logic [15:0] exp, input logic eb, input int susp);
    rd(flash_cfg_pkg::CMD_READ_CFG, {flash_cfg_pkg::RB_READY, exp}, eb, susp);
  endtask : rd_cfg

  task automatic rd_st(input logic [7:0] exp, input logic busy);
    rd(flash_cfg_pkg::CMD_READ_STAT, {busy ? flash_cfg_pkg::RB_BUSY : flash_cfg_pkg::RB_READY, exp, exp},
       1'b0, 999);
  endtask : rd_st

  task automatic cmd(input logic [7:0] op, input int nw);
    logic [31:0] v;
    logic        a;
    logic        b;
    host.frame(op, 16'h0000, nw, 0, 999, v, a, b);
  endtask : cmd

  task automatic wr_cfg(input logic [15:0] val);
    logic [31:0] v;
    logic        a;
    logic        b;
    host.frame(flash_cfg_pkg::CMD_WRITE_CFG, val & flash_cfg_pkg::CFG_WRITE_MASK, 24, 0, 999, v, a, b);
    check("stored cfg", nv_last, val);
  endtask : wr_cfg

  task automatic cmp(input logic m);
    @(posedge clk_i) cmp_valid <= 1'b1;
    cmp_mis <= m;
    @(posedge clk_i) cmp_valid <= 1'b0;
  endtask : cmp

  function automatic logic prot(input logic [3:0] c, input logic d, input int sec);
    int l;
    l = int'(c) << flash_cfg_pkg::BLOCK_SHIFT;
    if (c == flash_cfg_pkg::RANGE_ALL) return 1'b1;
    return d ? (sec >= 512 - l) : (sec < l);
  endfunction : prot
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end

  initial
  begin
    rst_n_i = 1'b0;
    wp_n = 1'b1;
    array_busy = 1'b0;
    xfer_busy = 1'b0;
    cmp_valid = 1'b0;
    cmp_mis = 1'b0;
    wr_sector = '0;
    nv_cfg = 16'h0009;
    nv_last = '0;
    do_reset(16'h0009);
    rd_cfg(16'h0009, 1'b0, 999);
    check("alt pump", alt_pump, 1'b0);
    rd_st(8'h00, 1'b0);
    @(posedge clk_i) wp_n <= 1'b0;
    cmd(flash_cfg_pkg::CMD_WR_ENABLE, 16);
    @(posedge clk_i) wp_n <= 1'b1;
    rd_st(8'h00, 1'b0);
    cmd(flash_cfg_pkg::CMD_WR_ENABLE, 16);
    rd_st(8'h10, 1'b0);
    @(posedge clk_i) array_busy <= 1'b1;
    rd_st(8'h90, 1'b1);
    @(posedge clk_i) array_busy <= 1'b0;
    xfer_busy <= 1'b1;
    rd_st(8'hd0, 1'b1);
    @(posedge clk_i) xfer_busy <= 1'b0;
    cmp(1'b0);
    cmp(1'b1);
    cmp(1'b0);
    rd_st(8'h18, 1'b0);
    cmd(flash_cfg_pkg::CMD_CLR_CMP, 24);
    cmp(1'b0);
    rd_st(8'h10, 1'b0);
    for (int f = 0; f < 4; f++)
    begin
      wr_cfg({14'h0002, 2'(f)});
      for (int b = 0; b < 2; b++)
      begin
        @(posedge clk_i) array_busy <= b[0];
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) check("pin enable", dual_oe, (f == 3) || (f == 2 && b == 1));
        if (f >= 2) check("pin level", dual_pin, !b[0]);
      end
      @(posedge clk_i) array_busy <= 1'b0;
    end
    wr_cfg(16'h0008);
    rd_cfg(16'h0008, 1'b0, 60);
    wr_cfg(16'h000d);
    rd_cfg(16'h000d, 1'b1, 999);
    @(posedge clk_i) array_busy <= 1'b1;
    cmd(flash_cfg_pkg::CMD_WRITE_CFG, 24);
    @(posedge clk_i) array_busy <= 1'b0;
    rd_cfg(16'h000d, 1'b1, 999);
    for (int d = 0; d < 2; d++)
      for (int c = 0; c < 16; c++)
      begin
        wr_cfg({8'h00, 4'(c), 1'(d), 3'b001});
        lim = c << flash_cfg_pkg::BLOCK_SHIFT;
        for (int k = 0; k < 6; k++)
        begin
          s = (k == 0) ? 0 : (k == 1) ? 511 : (k == 2) ? lim - 1 : (k == 3) ? lim : (k == 4) ? 511 - lim : 512 - lim;
          s = s & 511;
          @(posedge clk_i) wr_sector <= 9'(s);
          @(negedge clk_i) check("write allowed", wr_allowed, !prot(4'(c), d[0], s));
        end
      end
    wr_cfg(16'h0009);
    @(posedge clk_i) wp_n <= 1'b0;
    wr_sector <= '0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i) check("write allowed", wr_allowed, 1'b0);
    @(posedge clk_i) wp_n <= 1'b1;
    cmd(flash_cfg_pkg::CMD_WR_DISABLE, 16);
    @(negedge clk_i) check("write allowed", wr_allowed, 1'b0);
    wr_cfg(16'h010a);
    do_reset(16'h810a);
    rd_cfg(16'h010a, 1'b0, 999);
    check("alt pump", alt_pump, 1'b1);
    rd_st(8'h00, 1'b0);
    finish_test();
  end
endmodule : testbench
